// File: design/tedg_pkg.sv
// Package: states, line signal codes and timing constants of the guard
package tedg_pkg;

  // Layer 1 terminal states F1..F8
  typedef enum logic [2:0] {
    ST_INACTIVE,
    ST_SENSING,
    ST_DEACTIVATED,
    ST_AWAITING,
    ST_IDENTIFYING,
    ST_SYNCHRONIZED,
    ST_ACTIVATED,
    ST_LOST_FRAMING
  } tedg_state_t;

  // Received signal classes, as reported by the line receiver
  localparam logic [2:0] RX_NONE    = 3'h0;
  localparam logic [2:0] RX_INFO0   = 3'h1;
  localparam logic [2:0] RX_INFO2   = 3'h2;
  localparam logic [2:0] RX_INFO4   = 3'h3;
  localparam logic [2:0] RX_UNKNOWN = 3'h4;

  // Transmitted signal codes
  localparam logic [1:0] TX_INFO0 = 2'h0;
  localparam logic [1:0] TX_INFO1 = 2'h1;
  localparam logic [1:0] TX_INFO3 = 2'h3;

  // Clock rate and reaction window for an unknown continuous signal
  localparam int CLK_KHZ         = 125000;
  localparam int REACT_MIN_US    = 250;
  localparam int REACT_MAX_MS    = 25;
  // Least time rounds up, longest rounds down
  localparam int REACT_MIN_CYC   = (REACT_MIN_US * CLK_KHZ + 999) / 1000;
  localparam int REACT_MAX_CYC   = REACT_MAX_MS * CLK_KHZ;
  // Reaction taken at the middle of the window; default persistence time
  localparam int REACT_CYC       = (REACT_MIN_CYC + REACT_MAX_CYC) / 2;
  localparam int PERSIST_MS      = 500;
  localparam int PERSIST_CYC     = PERSIST_MS * CLK_KHZ;

endpackage

// File: design/tedg_timer.sv
// Down counter: load, count to zero, one-cycle expiry pulse
`timescale 1ns/1ns
`default_nettype none
module tedg_timer #(
  parameter int WIDTH = 32
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             arst_n_i,
  // Control
  input  wire logic             load_i,
  input  wire logic             cancel_i,
  input  wire logic [WIDTH-1:0] count_i,
  // Status
  output logic                  run_o,
  output logic                  expire_o
);

  typedef struct packed {
    logic [WIDTH-1:0] cnt;
    logic             run;
    logic             expire;
  } tedg_tmr_t;

  tedg_tmr_t r;
  tedg_tmr_t next_r;

  // Elaboration check: the countdown compare needs at least two bits
  if (WIDTH < 2)
  begin : g_bad_width
    $error("tedg_timer: WIDTH too small");
  end

  // Load wins over cancel so a fresh start is never lost
  always_comb
  begin
    next_r        = r;
    next_r.expire = 1'b0;
    if (load_i)
    begin
      next_r.cnt = count_i;
      next_r.run = 1'b1;
    end
    else if (cancel_i)
    begin
      next_r.run = 1'b0;
    end
    else if (r.run)
    begin
      if (r.cnt <= {{(WIDTH-1){1'b0}}, 1'b1})
      begin
        next_r.run    = 1'b0;
        next_r.expire = 1'b1;
      end
      else
      begin
        next_r.cnt = r.cnt - {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end

  // State register
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      r <= '0;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign run_o    = r.run;
  assign expire_o = r.expire;

endmodule
`default_nettype wire

// File: design/tedg_guard.sv
// Terminal layer 1 activation machine with deactivation guard
// Function
// - Unknown signal in F6/F7: INFO 0 within window
// - Start persistence timer on INFO 0 exit from F7 or F8
// - Deactivation indication only on expiry before reactivation
// - Withhold INFO 1 on foreign line signals
// - States F1-F8 with their transmitted INFO
`timescale 1ns/1ns
`default_nettype none
module tedg_guard #(
  parameter int REACT_CYC   = tedg_pkg::REACT_CYC,
  parameter int PERSIST_CYC = tedg_pkg::PERSIST_CYC
) (
  // Clock and reset
  input  wire logic       CORE_CLK_I,
  input  wire logic       ARST_N_I,
  // Line receiver classification, same clock domain
  input  wire logic [2:0] RX_CLASS_I,
  input  wire logic       RX_FRAMED_I,
  // Layer 2 and management requests, one-cycle pulses; POWER_OK_I is a level, low forces F1
  input  wire logic       ACT_REQ_I,
  input  wire logic       POWER_OK_I,
  input  wire logic       T3_EXPIRE_I,
  // Transmitter and state
  output logic [1:0]      TX_INFO_O,
  output logic [2:0]      STATE_O,
  // Indications to layer 2, one-cycle pulses
  output logic            ACT_IND_O,
  output logic            DEACT_IND_O
);

  typedef struct packed {
    tedg_pkg::tedg_state_t st;
    logic [31:0]           react_cnt;
    logic [1:0]            tx;
    logic                  act_ind;
    logic                  deact_ind;
  } tedg_main_t;

  tedg_main_t r;
  tedg_main_t next_r;
  logic       t_load;
  logic       t_cancel;
  logic       t_expire;
  logic       foreign;

  // Elaboration checks: reaction inside its window, hold time positive
  if (REACT_CYC < tedg_pkg::REACT_MIN_CYC ||
      REACT_CYC > tedg_pkg::REACT_MAX_CYC)
  begin : g_bad_react
    $error("tedg_guard: REACT_CYC outside reaction window");
  end
  if (PERSIST_CYC < 1)
  begin : g_bad_persist
    $error("tedg_guard: PERSIST_CYC must be positive");
  end

  // Foreign signal: anything not INFO 0, 2 or 4 while a signal is present
  assign foreign = (RX_CLASS_I != tedg_pkg::RX_INFO0) &&
                   (RX_CLASS_I != tedg_pkg::RX_INFO2) &&
                   (RX_CLASS_I != tedg_pkg::RX_INFO4) &&
                   (RX_CLASS_I != tedg_pkg::RX_NONE);

  // Persistence timer
  tedg_timer #(
    .WIDTH (32)
  ) u_persist (
    .clk_i    (CORE_CLK_I),
    .arst_n_i (ARST_N_I),
    .load_i   (t_load),
    .cancel_i (t_cancel),
    .count_i  (32'(PERSIST_CYC)),
    .run_o    (),
    .expire_o (t_expire)
  );

  // Next state, timer control and transmitter choice
  always_comb
  begin
    next_r           = r;
    next_r.act_ind   = 1'b0;
    next_r.deact_ind = 1'b0;
    t_load           = 1'b0;
    t_cancel         = 1'b0;
    if (!POWER_OK_I)
    begin
      next_r.st        = tedg_pkg::ST_INACTIVE;
      next_r.react_cnt = '0;
      t_cancel         = 1'b1;
    end
    else
    begin
      unique case (r.st)
        tedg_pkg::ST_INACTIVE:
        begin
          next_r.st = tedg_pkg::ST_SENSING;
        end
        tedg_pkg::ST_SENSING:
        begin
          next_r.st = tedg_pkg::ST_DEACTIVATED;
        end
        tedg_pkg::ST_DEACTIVATED:
        begin
          if (ACT_REQ_I)
          begin
            next_r.st = tedg_pkg::ST_AWAITING;
          end
          else if (RX_CLASS_I != tedg_pkg::RX_NONE &&
                   RX_CLASS_I != tedg_pkg::RX_INFO0)
          begin
            next_r.st = tedg_pkg::ST_IDENTIFYING;
          end
        end
        tedg_pkg::ST_AWAITING:
        begin
          if (T3_EXPIRE_I)
          begin
            next_r.st = tedg_pkg::ST_DEACTIVATED;
          end
          else if (RX_CLASS_I != tedg_pkg::RX_NONE &&
                   RX_CLASS_I != tedg_pkg::RX_INFO0)
          begin
            next_r.st = tedg_pkg::ST_IDENTIFYING;
          end
        end
        tedg_pkg::ST_IDENTIFYING:
        begin
          if (RX_CLASS_I == tedg_pkg::RX_INFO2)
          begin
            next_r.st = tedg_pkg::ST_SYNCHRONIZED;
          end
          else if (RX_CLASS_I == tedg_pkg::RX_INFO4)
          begin
            next_r.st = tedg_pkg::ST_ACTIVATED;
          end
          else if (RX_CLASS_I == tedg_pkg::RX_INFO0)
          begin
            next_r.st = tedg_pkg::ST_DEACTIVATED;
          end
        end
        tedg_pkg::ST_SYNCHRONIZED:
        begin
          if (RX_CLASS_I == tedg_pkg::RX_INFO4)
          begin
            next_r.st = tedg_pkg::ST_ACTIVATED;
          end
          else if (RX_CLASS_I == tedg_pkg::RX_INFO0)
          begin
            next_r.st = tedg_pkg::ST_DEACTIVATED;
          end
          else if (!RX_FRAMED_I && RX_CLASS_I != tedg_pkg::RX_UNKNOWN)
          begin
            next_r.st = tedg_pkg::ST_LOST_FRAMING;
          end
        end
        tedg_pkg::ST_ACTIVATED:
        begin
          if (RX_CLASS_I == tedg_pkg::RX_INFO0)
          begin
            next_r.st = tedg_pkg::ST_DEACTIVATED;
            t_load    = 1'b1;
          end
          else if (RX_CLASS_I == tedg_pkg::RX_INFO2)
          begin
            next_r.st = tedg_pkg::ST_SYNCHRONIZED;
          end
          // leaving for F8 would send INFO 0 too early
          else if (!RX_FRAMED_I && RX_CLASS_I != tedg_pkg::RX_UNKNOWN)
          begin
            next_r.st = tedg_pkg::ST_LOST_FRAMING;
          end
        end
        tedg_pkg::ST_LOST_FRAMING:
        begin
          if (RX_CLASS_I == tedg_pkg::RX_INFO0)
          begin
            next_r.st = tedg_pkg::ST_DEACTIVATED;
            t_load    = 1'b1;
          end
          else if (RX_CLASS_I == tedg_pkg::RX_INFO2 && RX_FRAMED_I)
          begin
            next_r.st = tedg_pkg::ST_SYNCHRONIZED;
          end
          else if (RX_CLASS_I == tedg_pkg::RX_INFO4 && RX_FRAMED_I)
          begin
            next_r.st = tedg_pkg::ST_ACTIVATED;
          end
        end
      endcase

      if ((r.st == tedg_pkg::ST_SYNCHRONIZED ||
           r.st == tedg_pkg::ST_ACTIVATED) &&
          RX_CLASS_I == tedg_pkg::RX_UNKNOWN)
      begin
        next_r.react_cnt = r.react_cnt + 32'h1;
      end
      else
      begin
        next_r.react_cnt = '0;
      end
    end

    if (next_r.st == tedg_pkg::ST_ACTIVATED && r.st != tedg_pkg::ST_ACTIVATED)
    begin
      next_r.act_ind = 1'b1;
      t_cancel       = 1'b1;
    end
    if (t_expire && r.st != tedg_pkg::ST_ACTIVATED)
    begin
      next_r.deact_ind = 1'b1;
    end

    unique case (next_r.st)
      tedg_pkg::ST_AWAITING:     next_r.tx = tedg_pkg::TX_INFO1;
      tedg_pkg::ST_SYNCHRONIZED: next_r.tx = tedg_pkg::TX_INFO3;
      tedg_pkg::ST_ACTIVATED:    next_r.tx = tedg_pkg::TX_INFO3;
      default:                   next_r.tx = tedg_pkg::TX_INFO0;
    endcase
    if (next_r.tx == tedg_pkg::TX_INFO1 && foreign)
    begin
      next_r.tx = tedg_pkg::TX_INFO0;
    end
    if (next_r.react_cnt >= 32'(REACT_CYC))
    begin
      next_r.tx        = tedg_pkg::TX_INFO0;
      next_r.react_cnt = 32'(REACT_CYC);
    end
  end

  // timer reload cancels pending expiry
  // State register; timer restart handled inside tedg_timer (load wins)
  always_ff @(posedge CORE_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      r <= '0;
    end
    else
    begin
      r <= next_r;
    end
  end

  // Outputs, all from flip-flops
  assign TX_INFO_O   = r.tx;
  assign STATE_O     = r.st;
  assign ACT_IND_O   = r.act_ind;
  assign DEACT_IND_O = r.deact_ind;

endmodule
`default_nettype wire

// File: dv/tedg_line.sv
// Line model: what the receiver reports from the network side
`timescale 1ns/1ns
`default_nettype none
module tedg_line (
  // Clock, reset and wanted line signal
  input  wire logic       clk_i,
  input  wire logic       arst_n_i,
  input  wire logic [2:0] sig_i,
  // Receiver view
  output logic [2:0]      class_o,
  output logic            framed_o
);
  // One cycle of receiver delay; only INFO 2 and INFO 4 carry frames
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      class_o  <= 3'h0;
      framed_o <= 1'b0;
    end
    else
    begin
      class_o  <= sig_i;
      framed_o <= sig_i == 3'h2 || sig_i == 3'h3;
    end
  end
endmodule
`default_nettype wire

// File: dv/tedg_guard_properties.sv
// Checker: port properties of the deactivation guard
`timescale 1ns/1ns
`default_nettype none
module tedg_chk #(
  parameter int REACT_CYC   = tedg_pkg::REACT_CYC,
  parameter int PERSIST_CYC = tedg_pkg::PERSIST_CYC
) (
  input wire logic       CORE_CLK_I,
  input wire logic       ARST_N_I,
  input wire logic [2:0] RX_CLASS_I,
  input wire logic [1:0] TX_INFO_O,
  input wire logic [2:0] STATE_O,
  input wire logic       ACT_IND_O,
  input wire logic       DEACT_IND_O
);
  // Unknown run, time since exit, F7 seen since exit
  int         unk;
  int         since;
  logic       f7;
  logic [2:0] prv;
  logic       ex;
  logic       f67;
  assign ex  = (prv == 3'h6 || prv == 3'h7) && STATE_O == 3'h2;
  assign f67 = STATE_O == 3'h5 || STATE_O == 3'h6;
  // F7 flag starts set so no indication is legal before a first exit
  always_ff @(posedge CORE_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      unk   <= 0;
      since <= 0;
      f7    <= 1'b1;
      prv   <= 3'h0;
    end
    else
    begin
      unk   <= RX_CLASS_I == tedg_pkg::RX_UNKNOWN ? unk + 1 : 0;
      since <= ex ? 1 : since + 1;
      f7    <= !ex && (f7 || STATE_O == 3'h6);
      prv   <= STATE_O;
    end
  end
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (!ARST_N_I);
  sequence s_enter;
    STATE_O != 3'h6 ##1 STATE_O == 3'h6;
  endsequence
  a_react_early: assert property (
    f67 && unk > 0 && unk < tedg_pkg::REACT_MIN_CYC |-> TX_INFO_O == 2'h3)
    else $error("INFO 0 too early");
  a_react_late: assert property (
    f67 && unk >= REACT_CYC |-> TX_INFO_O == 2'h0)
    else $error("INFO 0 too late");
  a_info1_hold: assert property (
    RX_CLASS_I == tedg_pkg::RX_UNKNOWN |=> TX_INFO_O != 2'h1)
    else $error("INFO 1 on foreign signal");
  a_tx_quiet: assert property (
    STATE_O inside {3'h0, 3'h1, 3'h2, 3'h4, 3'h7} |-> TX_INFO_O == 2'h0)
    else $error("quiet state not INFO 0");
  a_tx_active: assert property (
    f67 && $past(RX_CLASS_I) != 3'h4 |-> TX_INFO_O == 2'h3)
    else $error("F6 or F7 not INFO 3");
  a_act_entry: assert property (
    s_enter |-> ACT_IND_O)
    else $error("no activation pulse");
  a_deact_time: assert property (
    DEACT_IND_O |-> since == PERSIST_CYC + 1)
    else $error("indication off time");
  a_deact_supp: assert property (
    DEACT_IND_O |-> !f7)
    else $error("indication after reactivation");
endmodule
bind tedg_guard tedg_chk #(
  .REACT_CYC(REACT_CYC),
  .PERSIST_CYC(PERSIST_CYC)
) i_chk (.CORE_CLK_I, .ARST_N_I, .RX_CLASS_I, .TX_INFO_O, .STATE_O,
  .ACT_IND_O, .DEACT_IND_O);
`default_nettype wire

// File: dv/tb_te_layer1_deactivation_guard.sv
// Bench: activation, unknown signal reaction, deactivation guard
`timescale 1ns/1ns
`default_nettype none
module tb_te_layer1_deactivation_guard;
  localparam int RC = 31250;
  localparam int PC = 20;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       act = 1'b0;
  logic       pwr = 1'b1;
  logic       t3 = 1'b0;
  logic [2:0] sig = 3'h0;
  logic [2:0] rxc;
  logic [2:0] st;
  logic [1:0] tx;
  logic       rxf;
  logic       ai;
  logic       di;
  int         mismatches = 0;
  int         n_checks = 0;
  int         na = 0;
  int         nd = 0;
  int         cyc = 0;
  tedg_line i_line (.clk_i(clk), .arst_n_i(rst_n), .sig_i(sig),
    .class_o(rxc), .framed_o(rxf));
  // Power and T3 are driven so their state exits get exercised
  tedg_guard #(.REACT_CYC(RC), .PERSIST_CYC(PC)) i_dut (
    .CORE_CLK_I(clk), .ARST_N_I(rst_n), .RX_CLASS_I(rxc),
    .RX_FRAMED_I(rxf), .ACT_REQ_I(act), .POWER_OK_I(pwr),
    .T3_EXPIRE_I(t3), .TX_INFO_O(tx), .STATE_O(st),
    .ACT_IND_O(ai), .DEACT_IND_O(di));
  initial forever #4 clk = ~clk;
  // Pulse counts and watchdog on the falling edge, clear of driving
  always @(negedge clk)
  begin
    na += int'(ai);
    nd += int'(di);
    cyc++;
    if (cyc == 60000)
    begin
      mismatches++;
      close_out();
    end
  end
  task automatic close_out;
    if (mismatches == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("ERROR %0t: got %0h expected %0h", $time, g, e);
    end
  endtask
  task automatic nap(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic go(input logic [2:0] s);
    @(posedge clk);
    sig <= s;
  endtask
  task automatic req_act;
    @(posedge clk);
    act <= 1'b1;
    @(posedge clk);
    act <= 1'b0;
  endtask
  task automatic wait_st(input logic [2:0] e);
    int i;
    for (i = 0; i < 200 && st !== e; i++)
      @(negedge clk);
    chk(st, e);
  endtask
  task automatic t_activate;
    int a;
    a = na;
    wait_st(3'h2);
    chk(tx, 2'h0);
    // Request meets a foreign signal: F4 entered, INFO 1 held back
    go(3'h4);
    req_act();
    nap(1);
    chk(st, 3'h3);
    chk(tx, 2'h0);
    wait_st(3'h4);
    chk(tx, 2'h0);
    go(3'h1);
    wait_st(3'h2);
    req_act();
    wait_st(3'h3);
    chk(tx, 2'h1);
    // Expiry of the external T3 drops back to F3
    @(posedge clk);
    t3 <= 1'b1;
    @(posedge clk);
    t3 <= 1'b0;
    nap(1);
    chk(st, 3'h2);
    chk(tx, 2'h0);
    req_act();
    wait_st(3'h3);
    go(3'h2);
    wait_st(3'h5);
    chk(tx, 2'h3);
    go(3'h3);
    wait_st(3'h6);
    nap(1);
    chk(na, a + 1);
  endtask
  task automatic t_unknown;
    int n;
    go(3'h4);
    for (n = 0; n < 40000 && tx !== 2'h0; n++)
      @(negedge clk);
    chk(n >= RC - 1 && n <= RC + 4, 1'b1);
    chk(st, 3'h6);
    go(3'h3);
    nap(3);
    chk(tx, 2'h3);
  endtask
  task automatic t_persist;
    int d;
    d = nd;
    go(3'h1);
    wait_st(3'h2);
    nap(PC);
    chk(nd, d);
    nap(2);
    chk(nd, d + 1);
  endtask
  // Regaining F7 inside the hold time must swallow the indication
  task automatic t_regain;
    int d;
    d = nd;
    go(3'h3);
    wait_st(3'h6);
    go(3'h1);
    wait_st(3'h2);
    nap(5);
    go(3'h3);
    wait_st(3'h6);
    nap(PC + 5);
    chk(nd, d);
    t_persist();
  endtask
  // A second exit, via F6 and F8, restarts the hold time
  task automatic t_restart;
    int d;
    go(3'h3);
    wait_st(3'h6);
    d = nd;
    go(3'h1);
    wait_st(3'h2);
    go(3'h2);
    wait_st(3'h5);
    go(3'h0);
    wait_st(3'h7);
    chk(tx, 2'h0);
    go(3'h1);
    wait_st(3'h2);
    nap(PC);
    chk(nd, d);
    nap(2);
    chk(nd, d + 1);
  endtask
  // Power loss drops to F1 and kills a pending indication
  task automatic t_power;
    int d;
    go(3'h3);
    wait_st(3'h6);
    d = nd;
    go(3'h1);
    wait_st(3'h2);
    @(posedge clk);
    pwr <= 1'b0;
    @(posedge clk);
    pwr <= 1'b1;
    nap(1);
    chk(st, 3'h0);
    chk(tx, 2'h0);
    nap(PC + 5);
    chk(nd, d);
    chk(st, 3'h2);
  endtask
  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_activate();
    t_unknown();
    t_persist();
    t_regain();
    t_restart();
    t_power();
    close_out();
  end
endmodule
`default_nettype wire
